/* File: logic/min_bus_map.svh */
// Constants for the minimum-mode bus control block
`ifndef MIN_BUS_MAP_SVH
`define MIN_BUS_MAP_SVH
// Cycle type codes as {select, direction, status}
`define CYC_CODE_INT_ACK_STROBE_N 3'h4
`define CYC_CODE_RD_IO 3'h5
`define CYC_CODE_WR_IO 3'h6
`define CYC_CODE_HALT 3'h7
`define CYC_CODE_FETCH 3'h0
`define CYC_CODE_RD_MEM 3'h1
`define CYC_CODE_WR_MEM 3'h2
`define CYC_CODE_PASSIVE 3'h3
// Field positions inside a cycle code
`define CYC_BIT_SEL 2
`define CYC_BIT_DIR 1
`define CYC_BIT_STS 0
// Clock cycles per half bus state
`define HALF_STATE_CLKS 2
// Output register reset: passive code, strobes high, no latch pulse, driven
`define PINS_RESET 8'h7b
`endif

/* File: logic/min_bus_pkg.sv */
// Types for the minimum-mode bus control block
package min_bus_pkg;
  `include "min_bus_map.svh"
  typedef enum logic [2:0] {
    ST_TI = 3'h0,
    ST_T1 = 3'h1,
    ST_T2 = 3'h2,
    ST_T3 = 3'h3,
    ST_TW = 3'h4,
    ST_T4 = 3'h5,
    ST_HOLD = 3'h6
  } bus_state_t;
  typedef enum logic [2:0] {
    CYC_INT_ACK_STROBE_N = `CYC_CODE_INT_ACK_STROBE_N,
    CYC_RD_IO = `CYC_CODE_RD_IO,
    CYC_WR_IO = `CYC_CODE_WR_IO,
    CYC_HALT = `CYC_CODE_HALT,
    CYC_FETCH = `CYC_CODE_FETCH,
    CYC_RD_MEM = `CYC_CODE_RD_MEM,
    CYC_WR_MEM = `CYC_CODE_WR_MEM,
    CYC_PASSIVE = `CYC_CODE_PASSIVE
  } cyc_t;
  typedef struct packed {
    logic sel;
    logic dir;
    logic sts;
    logic wr_n;
    logic int_ack_strobe_n_n;
    logic ale;
    logic den_n;
    logic oe;
  } pins_t;
endpackage

/* File: logic/phase_if.sv */
// Carrier for half-state tick and synchronised bus request
`timescale 1ns/1ps
interface phase_if;
  logic half_en;
  logic hold_s;
  modport src (output half_en, output hold_s);
  modport dst (input half_en, input hold_s);
endinterface

/* File: logic/half_state_gen.sv */
// Half-state tick divider and bus request synchroniser
`timescale 1ns/1ps
`include "min_bus_map.svh"
module half_state_gen #(
  parameter int HALF_DIV = `HALF_STATE_CLKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hold_req,
  phase_if.src ph
);
  localparam int CW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_DIV - 1);
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;
  logic sync1_r, sync2_r;

  // Divider next values
  always_comb begin
    cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
    tick_nxt = (cnt_r == LAST);
  end

  // Divider and two-stage synchroniser registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      sync1_r <= hold_req;
      sync2_r <= sync1_r;
    end
  end

  assign ph.half_en = tick_r;
  assign ph.hold_s = sync2_r;
endmodule

/* File: logic/min_bus_ctrl.sv */
// Minimum-mode bus control outputs and bus-grant handshake
// Operation
// - Select high for I/O, low for memory; inverse of top status bit.
// - Select valid from preceding T4 and stable to the cycle's final T4.
// - Write strobe low through T2, T3 and Tw of write cycles.
// - Interrupt-acknowledge strobe low through T2, T3 and Tw of acknowledge cycles.
// - Address latch pulse is active high.
// - Direction high transmit, low receive, same timing as select.
// - Transceiver enable low on memory, I/O and acknowledge cycles.
// - Read and acknowledge: enable from mid T2 to mid T4.
// - Write: enable from start of T2 to mid T4.
// - Grant rises at the middle of a clock state.
// - With grant, control outputs float at logic one.
// - Grant drops after request seen low; drive resumes at next cycle.
// - Low status bit with select and direction encodes cycle; 100 is acknowledge.
// - Other codes: 101,110,111,000,001,010,011 as listed.
// - Low status bit floats at logic one during hold.
`timescale 1ns/1ps
`include "min_bus_map.svh"
module min_bus_ctrl
  import min_bus_pkg::*;
#(
  parameter int HALF_DIV = `HALF_STATE_CLKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cyc_req,
  input wire cyc_t cyc_type,
  input wire logic wait_req,
  input wire logic hold_req,
  output logic cyc_ack,
  output logic io_mem_sel,
  output logic write_strobe_n,
  output logic int_ack_strobe_n,
  output logic addr_latch_en,
  output logic xcvr_direction,
  output logic xcvr_enable_n,
  output logic cycle_status_low,
  output logic ctl_oe,
  output logic bus_grant_ack
);
  phase_if ph ();

  half_state_gen #(
    .HALF_DIV(HALF_DIV)
  ) u_gen (
    .clk(clk),
    .arst_n(arst_n),
    .hold_req(hold_req),
    .ph(ph)
  );

  bus_state_t state_r, state_nxt;
  logic phase_r, phase_nxt;
  cyc_t type_r, type_nxt;
  logic go_r, go_nxt;
  logic float_r, float_nxt;
  logic ack_nxt;
  logic grant_r, grant_nxt;
  pins_t pins_r, pins_nxt;

  // Write cycles: direction set, status clear
  function automatic logic is_write(input cyc_t t);
    return t[`CYC_BIT_DIR] & ~t[`CYC_BIT_STS];
  endfunction

  // Cycles that move data through the transceiver
  function automatic logic uses_xcvr(input cyc_t t);
    return ~(t[`CYC_BIT_DIR] & t[`CYC_BIT_STS]);
  endfunction

  // Pin levels for a given state, half and cycle type
  function automatic pins_t drive(input bus_state_t s, input logic ph1, input cyc_t t,
                                  input logic flt);
    pins_t p;
    logic strb;
    logic den_w;
    logic den_r;
    p = '0;
    strb = (s == ST_T2) || (s == ST_T3) || (s == ST_TW);
    den_w = strb || ((s == ST_T4) && !ph1);
    den_r = ((s == ST_T2) && ph1) || (s == ST_T3) || (s == ST_TW) || ((s == ST_T4) && !ph1);
    p.ale = (s == ST_T1) && !ph1;
    if (flt) begin
      p.sel = 1'b1;
      p.dir = 1'b1;
      p.sts = 1'b1;
      p.wr_n = 1'b1;
      p.int_ack_strobe_n_n = 1'b1;
      p.den_n = 1'b1;
      p.oe = 1'b0;
    end else begin
      p.sel = t[`CYC_BIT_SEL];
      p.dir = t[`CYC_BIT_DIR];
      p.sts = t[`CYC_BIT_STS];
      p.wr_n = !(strb && is_write(t));
      p.int_ack_strobe_n_n = !(strb && (t == CYC_INT_ACK_STROBE_N));
      if (!uses_xcvr(t)) begin
        p.den_n = 1'b1;
      end else if (is_write(t)) begin
        p.den_n = !den_w;
      end else begin
        p.den_n = !den_r;
      end
      p.oe = 1'b1;
    end
    return p;
  endfunction

  // Bus state sequencing and grant handshake
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    type_nxt = type_r;
    go_nxt = go_r;
    float_nxt = float_r;
    ack_nxt = 1'b0;
    if (ph.half_en) begin
      phase_nxt = ~phase_r;
      if (!phase_r) begin
        if ((state_r == ST_TI) || (state_r == ST_T4)) begin
          if (ph.hold_s) begin
            state_nxt = ST_HOLD;
            float_nxt = 1'b1;
            go_nxt = 1'b0;
          end else if (cyc_req) begin
            type_nxt = cyc_type;
            float_nxt = 1'b0;
            go_nxt = 1'b1;
            ack_nxt = 1'b1;
          end
        end
      end else begin
        unique case (state_r)
          ST_TI, ST_T4: begin
            if (go_r) begin
              state_nxt = ST_T1;
              go_nxt = 1'b0;
            end else begin
              state_nxt = ST_TI;
              if (!float_r) begin
                type_nxt = CYC_PASSIVE;
              end
            end
          end
          ST_T1: state_nxt = ST_T2;
          ST_T2: state_nxt = ST_T3;
          ST_T3, ST_TW: state_nxt = wait_req ? ST_TW : ST_T4;
          ST_HOLD: begin
            if (!ph.hold_s) begin
              state_nxt = ST_TI;
            end
          end
          default: state_nxt = ST_TI;
        endcase
      end
    end
    pins_nxt = drive(state_nxt, phase_nxt, type_nxt, float_nxt);
    grant_nxt = (state_nxt == ST_HOLD);
  end

  // State and output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_TI;
      phase_r <= 1'b0;
      type_r <= CYC_PASSIVE;
      go_r <= 1'b0;
      float_r <= 1'b0;
      cyc_ack <= 1'b0;
      grant_r <= 1'b0;
      pins_r <= pins_t'(`PINS_RESET);
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      type_r <= type_nxt;
      go_r <= go_nxt;
      float_r <= float_nxt;
      cyc_ack <= ack_nxt;
      grant_r <= grant_nxt;
      pins_r <= pins_nxt;
    end
  end

  // Pin outputs straight from the output register
  assign io_mem_sel = pins_r.sel;
  assign xcvr_direction = pins_r.dir;
  assign cycle_status_low = pins_r.sts;
  assign write_strobe_n = pins_r.wr_n;
  assign int_ack_strobe_n = pins_r.int_ack_strobe_n_n;
  assign addr_latch_en = pins_r.ale;
  assign xcvr_enable_n = pins_r.den_n;
  assign ctl_oe = pins_r.oe;
  assign bus_grant_ack = grant_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic active;
  assign active = (state_r == ST_T1) || (state_r == ST_T2) || (state_r == ST_T3) ||
                  (state_r == ST_TW);

  property p_ale_t1;
    addr_latch_en |-> (state_r == ST_T1) && !phase_r && ctl_oe;
  endproperty
  a_ale_t1: assert property (p_ale_t1) else $error("latch pulse outside T1");

  property p_wr_strobe;
    (active && (state_r != ST_T1) && is_write(type_r)) |-> !write_strobe_n;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");

  property p_int_ack_strobe_n_strobe;
    !int_ack_strobe_n |-> (type_r == CYC_INT_ACK_STROBE_N) && active && (state_r != ST_T1);
  endproperty
  a_int_ack_strobe_n_strobe: assert property (p_int_ack_strobe_n_strobe) else $error("ack strobe misplaced");

  property p_sel_stable;
    (active && $past(active)) |-> $stable(io_mem_sel) && $stable(xcvr_direction);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("select changed in cycle");

  property p_den_read;
    (!xcvr_enable_n && !is_write(type_r)) |->
      !((state_r == ST_T2) && !phase_r) && !((state_r == ST_T4) && phase_r);
  endproperty
  a_den_read: assert property (p_den_read) else $error("read enable window wrong");

  property p_den_write;
    ((state_r == ST_T2) && is_write(type_r) && ctl_oe) |-> !xcvr_enable_n;
  endproperty
  a_den_write: assert property (p_den_write) else $error("write enable late");

  property p_grant_origin;
    $rose(bus_grant_ack) |-> ($past(state_r) == ST_TI) || ($past(state_r) == ST_T4);
  endproperty
  a_grant_origin: assert property (p_grant_origin) else $error("grant cut a cycle");

  property p_float;
    bus_grant_ack |-> !ctl_oe && io_mem_sel && xcvr_direction && write_strobe_n &&
                      xcvr_enable_n && cycle_status_low && !addr_latch_en;
  endproperty
  a_float: assert property (p_float) else $error("outputs not floated high");

  property p_grant_drop;
    $fell(bus_grant_ack) |-> !$past(ph.hold_s) && !ctl_oe;
  endproperty
  a_grant_drop: assert property (p_grant_drop) else $error("grant dropped early");

  property p_encode;
    ctl_oe |-> {io_mem_sel, xcvr_direction, cycle_status_low} == type_r;
  endproperty
  a_encode: assert property (p_encode) else $error("cycle code mismatch");

  property p_den_used;
    ((state_r == ST_T3) && uses_xcvr(type_r)) |-> !xcvr_enable_n;
  endproperty
  a_den_used: assert property (p_den_used) else $error("enable missing in T3");

  c_write: cover property ((state_r == ST_T3) && (type_r == CYC_WR_MEM));
  c_int_ack_strobe_n: cover property (!int_ack_strobe_n);
  c_wait: cover property (state_r == ST_TW);
  c_hold: cover property ($rose(bus_grant_ack) ##[1:200] $fell(bus_grant_ack));
endmodule

/* File: sim/bus_far_side.sv */
// Far-side model: other bus master and slow memory
`timescale 1ns/1ps
module bus_far_side (
  input wire logic clk,
  input wire logic want_bus,
  input wire logic slow,
  input wire logic strobe_n,
  input wire logic bus_grant_ack,
  output logic hold_req,
  output logic wait_req
);
  int wcnt = 0;
  initial hold_req = 1'b0;
  initial wait_req = 1'b0;
  // Request changes only at the clock edge and stays up until want_bus is low and grant is seen
  always @(posedge clk) begin
    if (want_bus) begin
      hold_req <= 1'b1;
    end else if (bus_grant_ack) begin
      hold_req <= 1'b0;
    end
  end
  // Slow memory stretches an active transfer window by one wait state
  always @(posedge clk) begin
    wcnt <= strobe_n ? 0 : wcnt + 1;
    wait_req <= slow && !strobe_n && wcnt < 3;
  end
endmodule

/* File: sim/min_bus_ctrl_tb_top.sv */
// Testbench for the minimum-mode bus control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module min_bus_ctrl_tb_top;
  import min_bus_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc_req = 1'b0;
  cyc_t cyc_type = CYC_FETCH;
  logic want = 1'b0;
  logic slow = 1'b0;
  logic wait_req, hold_req, cyc_ack, io_mem_sel, write_strobe_n, int_ack_strobe_n;
  logic addr_latch_en, xcvr_direction, xcvr_enable_n, cycle_status_low, ctl_oe;
  logic bus_grant_ack;
  int n_fail = 0;
  int n_checks = 0;
  int wr_len, ia_len, den_len, ale_len;
  always #4 clk = ~clk;
  min_bus_ctrl #(.HALF_DIV(1)) i_dut (.clk(clk), .arst_n(arst_n), .cyc_req(cyc_req),
    .cyc_type(cyc_type), .wait_req(wait_req), .hold_req(hold_req), .cyc_ack(cyc_ack),
    .io_mem_sel(io_mem_sel), .write_strobe_n(write_strobe_n),
    .int_ack_strobe_n(int_ack_strobe_n), .addr_latch_en(addr_latch_en),
    .xcvr_direction(xcvr_direction), .xcvr_enable_n(xcvr_enable_n),
    .cycle_status_low(cycle_status_low), .ctl_oe(ctl_oe), .bus_grant_ack(bus_grant_ack));
  bus_far_side i_far (.clk(clk), .want_bus(want), .slow(slow),
    .strobe_n(xcvr_enable_n), .bus_grant_ack(bus_grant_ack),
    .hold_req(hold_req), .wait_req(wait_req));
  // Length of each strobe and pulse within one test
  always @(posedge clk) begin
    wr_len += (write_strobe_n === 1'b0);
    ia_len += (int_ack_strobe_n === 1'b0);
    den_len += (xcvr_enable_n === 1'b0);
    ale_len += (addr_latch_en === 1'b1);
  end
  task automatic conclude;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_until(ref logic s, input logic v);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (s !== v && k < 100);
    `CHK(s, v)
  endtask
  task automatic clear_counts;
    wr_len = 0;
    ia_len = 0;
    den_len = 0;
    ale_len = 0;
  endtask
  // One bus cycle of the given type, optionally with wait states
  task automatic run_cyc(input cyc_t t, input logic sl);
    int wr_e, ia_e, den_e, tw;
    tw = sl ? 2 : 0; // One Tw of two half states when slow
    wr_e = (t == CYC_WR_MEM || t == CYC_WR_IO) ? 4 + tw : 0;
    ia_e = (t == CYC_INT_ACK_STROBE_N) ? 4 + tw : 0;
    den_e = (t == CYC_HALT || t == CYC_PASSIVE) ? 0 : 4 + tw + (wr_e != 0);
    @(posedge clk);
    clear_counts();
    slow <= sl;
    cyc_type <= t;
    cyc_req <= 1'b1;
    wait_until(cyc_ack, 1'b1);
    `CHK({io_mem_sel, xcvr_direction, cycle_status_low}, 3'(t))
    `CHK(ctl_oe, 1'b1)
    @(posedge clk);
    cyc_req <= 1'b0;
    repeat (24) @(posedge clk);
    #1;
    if (sl) begin
      `CHK(wr_len, wr_e)
      `CHK(den_len, den_e)
    end else begin
      `CHK(wr_len, wr_e)
      `CHK(ia_len, ia_e)
      `CHK(den_len, den_e)
    end
    `CHK(ale_len, 1)
    `CHK({io_mem_sel, xcvr_direction, cycle_status_low}, 3'h3)
    $display("test cycle %0h slow %0d done", t, sl);
  endtask
  // Hold requested during a write: cycle completes, then bus floats
  task automatic run_hold;
    @(posedge clk);
    clear_counts();
    slow <= 1'b0;
    cyc_type <= CYC_WR_MEM;
    cyc_req <= 1'b1;
    wait_until(cyc_ack, 1'b1);
    @(posedge clk);
    cyc_req <= 1'b0;
    want <= 1'b1;
    wait_until(bus_grant_ack, 1'b1);
    `CHK(wr_len, 4)
    `CHK(ctl_oe, 1'b0)
    `CHK({io_mem_sel, write_strobe_n, int_ack_strobe_n}, 3'h7)
    `CHK({xcvr_direction, xcvr_enable_n, cycle_status_low}, 3'h7)
    `CHK(addr_latch_en, 1'b0)
    repeat (6) @(posedge clk);
    #1;
    `CHK(bus_grant_ack, 1'b1)
    @(posedge clk);
    want <= 1'b0;
    wait_until(bus_grant_ack, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    `CHK(ctl_oe, 1'b0)
    $display("test hold done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1;
    `CHK({io_mem_sel, xcvr_direction, cycle_status_low, ctl_oe, bus_grant_ack}, 5'h0e)
    @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      run_cyc(cyc_t'(i), 1'b0);
    end
    run_cyc(CYC_WR_IO, 1'b1);
    run_cyc(CYC_RD_IO, 1'b1);
    run_hold();
    run_cyc(CYC_FETCH, 1'b0);
    conclude();
  end
  // Watchdog well beyond the expected run
  initial begin
    #40000;
    n_fail++;
    conclude();
  end
endmodule
